/* File: dv/scpi_status_reporting_tb_top.sv */
// self-checking bench for the status register bank
`define CHK(a, b, m) begin compares++; if ((a) !== (b)) begin err_total++; $display("CHECK FAILED %0t %s", $time, m); end end
module scpi_status_reporting_tb_top
    import status_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        core_clk = 1'b0;
    logic        rst      = 1'b1;
    logic        exec_idle = 1'b1;
    logic [4:0]  op_in    = 5'h00;
    logic [2:0]  qc_in    = 3'h0;
    logic [3:0]  errs     = 4'h0;
    logic [32:0] nv_mem   = '0;
    logic        cmd_valid, rsp_valid, error_clear, nv_store, srq;
    logic [4:0]  cmd_code;
    logic [7:0]  cmd_param, rsp_data, r, d;
    logic [32:0] nv_image;
    int          err_total = 0;
    int          compares  = 0;
    int          clr_cnt   = 0;
    localparam logic [7:0] ids [4] = '{8'h3C, 8'h42, 8'h07, 8'h21}; // arbitrary values

    always #20 core_clk = ~core_clk;

    // ------------------------------------------------------------
    // instances and nonvolatile store
    // ------------------------------------------------------------
    scpi_status_reporting #(.MAKER_ID(ids[0]), .MODEL_ID(ids[1]), .SERIAL_ID(ids[2]), .VERSION_ID(ids[3]))
    i_scpi_status_reporting (
        .CORE_CLK(core_clk), .RST(rst), .CMD_VALID(cmd_valid), .CMD_CODE(cmd_code), .CMD_PARAM(cmd_param),
        .EXEC_IDLE(exec_idle), .CAL_ACTIVE(op_in[0]), .TRIGGER_WAIT_FLAG(op_in[1]),
        .CONST_VOLTAGE_FLAG(op_in[2]), .CONST_CURRENT_FLAG(op_in[3]), .REMOTE_INPUT_LEVEL(op_in[4]),
        .OVERVOLTAGE_FLAG(qc_in[0]), .OVERTEMP_FLAG(qc_in[1]), .UNREGULATED_FLAG(qc_in[2]),
        .QUERY_ERROR(errs[0]), .DEVICE_ERROR(errs[1]), .EXEC_ERROR(errs[2]), .COMMAND_ERROR(errs[3]),
        .NV_RESTORE_IN(nv_mem), .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data), .ERROR_CLEAR(error_clear),
        .NV_STORE(nv_store), .NV_IMAGE(nv_image), .SERVICE_REQUEST(srq));

    status_host host (.clk(core_clk), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .cmd_param(cmd_param));

    // storage keeps the image across resets, as the real memory would
    always @(posedge core_clk) begin
        if (nv_store === 1'b1) nv_mem <= nv_image;
        if (error_clear === 1'b1) clr_cnt++;
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic do_reset();
        @(posedge core_clk); // a store pulse from the last write must reach memory first
        rst <= 1'b1;
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        repeat (2) @(posedge core_clk); // load cycle ignores commands
    endtask : do_reset

    task automatic qchk(input cmd_t c, input logic [7:0] p, input logic [7:0] e, input string m);
        host.query(c, p, d);
        `CHK(d, e, m)
    endtask : qchk

    task automatic complete_run();
        if (err_total == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : complete_run

    initial begin
        repeat (20000) @(posedge core_clk);
        err_total++;
        complete_run();
    end

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        void'($urandom(64));
        do_reset();
        qchk(CMD_ESR_Q, 8'h00, 8'h80, "power-on bit after reset");
        qchk(CMD_ESR_Q, 8'h00, 8'h00, "event status not cleared by query");
        for (int i = 0; i < 4; i++) qchk(CMD_IDN_Q, 8'(i), ids[i], "identity field");
        // operation and questionable conditions with all enables open
        host.send(CMD_OEN_W, 8'hFF);
        host.send(CMD_QEN_W, 8'hFF);
        r = 8'(($urandom % 31) + 1);
        @(posedge core_clk);
        op_in <= r[4:0];
        qc_in <= 3'(($urandom % 7) + 1);
        repeat (4) @(posedge core_clk);
        qchk(CMD_OCND_Q, 8'h00, r, "operation condition");
        qchk(CMD_QCND_Q, 8'h00, {5'h00, qc_in}, "questionable condition");
        qchk(CMD_OEV_Q, 8'h00, r, "operation event");
        qchk(CMD_OEV_Q, 8'h00, 8'h00, "operation event not cleared");
        qchk(CMD_QEV_Q, 8'h00, {5'h00, qc_in}, "questionable event");
        qchk(CMD_QEV_Q, 8'h00, 8'h00, "questionable event not cleared");
        host.query(CMD_STB_Q, 8'h00, d);
        `CHK(d[7], 1'b1, "operation summary")
        `CHK(d[3], 1'b1, "questionable summary")
        qchk(CMD_STB_Q, 8'h00, 8'h00, "status byte not cleared");
        // each error input lands on its own event bit; one bit enabled
        r = 8'h04 << ($urandom % 4);
        host.send(CMD_ESE_W, r);
        host.send(CMD_SRE_W, 8'h20);
        qchk(CMD_ESE_Q, 8'h00, r, "event enable readback");
        `CHK(nv_image[23:16], r, "event enable image")
        qchk(CMD_SRE_Q, 8'h00, 8'h20, "request enable readback");
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk);
            errs <= 4'(1 << i);
            @(posedge core_clk);
            errs <= 4'h0;
        end
        repeat (4) @(posedge core_clk);
        `CHK(srq, 1'b1, "service request not raised")
        qchk(CMD_STB_Q, 8'h00, 8'h60, "summary bit and request bit");
        repeat (2) @(posedge core_clk);
        `CHK(srq, 1'b0, "service request stuck")
        qchk(CMD_ESR_Q, 8'h00, 8'h3C, "error bit positions");
        // clear-status after a fresh error
        @(posedge core_clk);
        errs <= 4'h4;
        @(posedge core_clk);
        errs <= 4'h0;
        host.send(CMD_CLS, 8'h00);
        repeat (2) @(posedge core_clk);
        `CHK(clr_cnt, 1, "error code clear pulse")
        qchk(CMD_ESR_Q, 8'h00, 8'h00, "event status after clear");
        qchk(CMD_STB_Q, 8'h00, 8'h00, "status byte after clear");
        // operation complete waits for the executor
        @(posedge core_clk);
        exec_idle <= 1'b0;
        host.send(CMD_OPC_W, 8'h00);
        repeat (5) @(posedge core_clk);
        qchk(CMD_ESR_Q, 8'h00, 8'h00, "completion bit too early");
        @(posedge core_clk);
        exec_idle <= 1'b1;
        repeat (3) @(posedge core_clk);
        qchk(CMD_ESR_Q, 8'h00, 8'h01, "completion bit");
        qchk(CMD_OPC_Q, 8'h00, 8'h01, "completion query");
        // power-on-clear set: enables cleared across reset
        host.send(CMD_PSC_W, 8'h01);
        qchk(CMD_PSC_Q, 8'h00, 8'h01, "clear flag readback");
        host.send(CMD_ESE_W, 8'(($urandom % 255) + 1));
        do_reset();
        qchk(CMD_ESE_Q, 8'h00, 8'h00, "event enable kept");
        qchk(CMD_OEN_Q, 8'h00, 8'h00, "operation enable kept");
        qchk(CMD_QEN_Q, 8'h00, 8'h00, "questionable enable kept");
        // power-on-clear off: enables restored
        host.send(CMD_PSC_W, 8'h00);
        r = 8'($urandom);
        host.send(CMD_ESE_W, r);
        host.send(CMD_OEN_W, 8'h1F);
        do_reset();
        qchk(CMD_PSC_Q, 8'h00, 8'h00, "clear flag restore");
        qchk(CMD_ESE_Q, 8'h00, r, "event enable restore");
        qchk(CMD_OEN_Q, 8'h00, 8'h1F, "operation enable restore");
        complete_run();
    end
endmodule : scpi_status_reporting_tb_top

/* File: dv/status_host.sv */
// remote controller model: issues status commands and collects answers
module status_host
    import status_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rsp_valid,
    input  wire logic [7:0] rsp_data,
    output logic            cmd_valid,
    output logic      [4:0] cmd_code,
    output logic      [7:0] cmd_param
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // command strobe
    // ------------------------------------------------------------
    initial begin
        cmd_valid = 1'b0;
        cmd_code  = 5'h00;
        cmd_param = 8'h00;
    end

    // one-cycle strobe, code and parameter held with it
    task automatic send(input cmd_t c, input logic [7:0] p);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_code  <= c;
        cmd_param <= p;
        @(posedge clk);
        cmd_valid <= 1'b0;
    endtask : send

    // wait bounded; a missing answer leaves unknown data so the compare fails
    task automatic query(input cmd_t c, input logic [7:0] p, output logic [7:0] d);
        int n;
        n = 0;
        d = 8'hxx;
        send(c, p);
        #1;
        while (rsp_valid !== 1'b1 && n < 8) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (rsp_valid === 1'b1) begin
            d = rsp_data;
        end
    endtask : query
endmodule : status_host

/* File: verilog/cond_event.sv */
// condition register with transition-latched event register
module cond_event
    import status_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] cond_in,
    input  wire logic [WIDTH-1:0] enable,
    input  wire logic             clear,
    output logic      [WIDTH-1:0] cond_q,
    output logic      [WIDTH-1:0] event_q,
    output logic                  hit_q
);

    // answers are one byte wide, so wider registers cannot be returned
    if (WIDTH < 1 || WIDTH > 8) begin : g_bad_width
        $error("cond_event WIDTH must be 1..8");
    end

    typedef struct packed {
        logic [WIDTH-1:0] cond;
        logic [WIDTH-1:0] evt;
        logic             hit;
        logic             armed;
    } ce_state_t;

    ce_state_t q;
    ce_state_t d;
    logic [WIDTH-1:0] change;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    // any change of a condition bit latches its event bit; set beats clear
    // first cycle after reset only takes the levels: a pin already high is no change
    always_comb begin
        d       = q;
        change  = q.armed ? (cond_in ^ q.cond) : '0;
        d.armed = 1'b1;
        d.cond = cond_in;
        d.evt  = (clear ? '0 : q.evt) | change;
        d.hit  = |(change & ~q.evt & enable);
    end

    // state register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign cond_q  = q.cond;
    assign event_q = q.evt;
    assign hit_q   = q.hit;

    a_change_latch: assert property (@(posedge clk) disable iff (rst)
        (q.armed && cond_in != cond_q) |=>
        ((event_q & ($past(cond_in) ^ $past(cond_q))) == ($past(cond_in) ^ $past(cond_q))))
        else $error("condition change did not latch its event bit");

endmodule : cond_event

/* File: verilog/scpi_status_reporting.sv */
// status register bank: condition, event, enable and summary registers

// Notes on behaviour
// - operation condition: calibrating, trigger wait, const voltage, const current, remote input level
// - questionable condition: overvoltage bit 0, overtemperature bit 1, unregulated bit 2
// - standard event bits: OPC 0, QYE 2, DDE 3, EXE 4, CME 5, PON 7
// - power-on bit of standard events is set by every reset
// - status byte bit 3 set when an enabled questionable event occurs
// - status byte bit 5 set when an enabled standard event bit becomes one
// - status byte bit 7 set when an enabled operation event occurs
// - clear-status empties standard events, both event registers, status byte, error code
// - standard event enable mask is written, read back and gates bit 5
// - standard event enable mask uses the standard event bit layout
// - standard event query returns the value then clears it
// - identification query yields maker, model, serial and version fields
// - operation-complete sets OPC once all earlier commands have finished
// - with power-on-clear at one, reset clears the three event enable masks
// - with power-on-clear at zero, masks are restored from nonvolatile storage
// - any condition bit change sets its event bit
// - event register query returns the value then clears it
// - status byte query returns the value then clears it
// - service request enable mask selects which status bits raise request-service
module scpi_status_reporting
    import status_pkg::*;
#(
    parameter logic [7:0] MAKER_ID   = 8'h5A, // arbitrary value
    parameter logic [7:0] MODEL_ID   = 8'h11, // arbitrary value
    parameter logic [7:0] SERIAL_ID  = 8'h01, // arbitrary value
    parameter logic [7:0] VERSION_ID = 8'h10  // arbitrary value
) (
    input  wire logic        CORE_CLK,
    input  wire logic        RST,
    input  wire logic        CMD_VALID,
    input  wire logic [4:0]  CMD_CODE,
    input  wire logic [7:0]  CMD_PARAM,
    input  wire logic        EXEC_IDLE,
    input  wire logic        CAL_ACTIVE,
    input  wire logic        TRIGGER_WAIT_FLAG,
    input  wire logic        CONST_VOLTAGE_FLAG,
    input  wire logic        CONST_CURRENT_FLAG,
    input  wire logic        REMOTE_INPUT_LEVEL,
    input  wire logic        OVERVOLTAGE_FLAG,
    input  wire logic        OVERTEMP_FLAG,
    input  wire logic        UNREGULATED_FLAG,
    input  wire logic        QUERY_ERROR,
    input  wire logic        DEVICE_ERROR,
    input  wire logic        EXEC_ERROR,
    input  wire logic        COMMAND_ERROR,
    input  wire logic [32:0] NV_RESTORE_IN,
    output logic             RSP_VALID,
    output logic      [7:0]  RSP_DATA,
    output logic             ERROR_CLEAR,
    output logic             NV_STORE,
    output logic      [32:0] NV_IMAGE,
    output logic             SERVICE_REQUEST
);

    typedef struct packed {
        state_t     st;
        logic [7:0] esr;
        logic [7:0] ese;
        logic [7:0] sre;
        logic [7:0] qen;
        logic [7:0] oen;
        logic       psc;
        logic [7:0] stb;
        logic       opc_set_pend;
        logic       opc_ans_pend;
        logic       rsp_valid;
        logic [7:0] rsp_data;
        logic       err_clr;
        logic       nv_store;
    } top_state_t;

    top_state_t q;
    top_state_t d;
    cmd_t       cmd;
    logic [7:0] esr_set;
    logic [7:0] operation_summary_cond_in;
    logic [7:0] questionable_summary_cond_in;
    logic [7:0] operation_summary_cond;
    logic [7:0] operation_summary_evt;
    logic [7:0] questionable_summary_cond;
    logic [7:0] questionable_summary_evt;
    logic       operation_summary_hit;
    logic       questionable_summary_hit;
    logic       operation_summary_clr;
    logic       questionable_summary_clr;
    logic       take;

    // ------------------------------------------------------------
    // condition inputs and event registers
    // ------------------------------------------------------------
    // pack the live conditions into their bit positions
    always_comb begin
        operation_summary_cond_in              = ZERO8;
        operation_summary_cond_in[OPC_CAL_POS] = CAL_ACTIVE;
        operation_summary_cond_in[OPC_WTG_POS] = TRIGGER_WAIT_FLAG;
        operation_summary_cond_in[OPC_CV_POS]  = CONST_VOLTAGE_FLAG;
        operation_summary_cond_in[OPC_CC_POS]  = CONST_CURRENT_FLAG;
        operation_summary_cond_in[OPC_RI_POS]  = REMOTE_INPUT_LEVEL;
        questionable_summary_cond_in              = ZERO8;
        questionable_summary_cond_in[QC_OV_POS]   = OVERVOLTAGE_FLAG;
        questionable_summary_cond_in[QC_OT_POS]   = OVERTEMP_FLAG;
        questionable_summary_cond_in[QC_UNR_POS]  = UNREGULATED_FLAG;
    end

    cond_event #(.WIDTH(8)) u_operation_summary (
        .clk     (CORE_CLK),
        .rst     (RST),
        .cond_in (operation_summary_cond_in),
        .enable  (q.oen),
        .clear   (operation_summary_clr),
        .cond_q  (operation_summary_cond),
        .event_q (operation_summary_evt),
        .hit_q   (operation_summary_hit)
    );

    cond_event #(.WIDTH(8)) u_questionable_summary (
        .clk     (CORE_CLK),
        .rst     (RST),
        .cond_in (questionable_summary_cond_in),
        .enable  (q.qen),
        .clear   (questionable_summary_clr),
        .cond_q  (questionable_summary_cond),
        .event_q (questionable_summary_evt),
        .hit_q   (questionable_summary_hit)
    );

    // ------------------------------------------------------------
    // command handling and summary logic
    // ------------------------------------------------------------
    // commands are taken only once the restore cycle is over
    always_comb begin
        d           = q;
        d.rsp_valid = 1'b0;
        d.err_clr   = 1'b0;
        d.nv_store  = 1'b0;
        cmd         = cmd_t'(CMD_CODE);
        take        = CMD_VALID && (q.st == ST_RUN);
        operation_summary_clr    = 1'b0;
        questionable_summary_clr    = 1'b0;
        esr_set     = ZERO8;
        esr_set[ESR_QYE] = QUERY_ERROR;
        esr_set[ESR_DDE] = DEVICE_ERROR;
        esr_set[ESR_EXE] = EXEC_ERROR;
        esr_set[ESR_CME] = COMMAND_ERROR;
        d.stb[STB_RQS]   = 1'b0;
        case (q.st)
            ST_LOAD: begin
                // power-on-clear policy decides whether masks survive reset
                d.psc = NV_RESTORE_IN[NV_PSC_POS];
                if (NV_RESTORE_IN[NV_PSC_POS]) begin
                    d.ese = ZERO8;
                    d.qen = ZERO8;
                    d.oen = ZERO8;
                    d.sre = ZERO8;
                end else begin
                    d.sre = NV_RESTORE_IN[NV_SRE_LSB +: 8];
                    d.ese = NV_RESTORE_IN[NV_ESE_LSB +: 8];
                    d.qen = NV_RESTORE_IN[NV_QEN_LSB +: 8];
                    d.oen = NV_RESTORE_IN[NV_OEN_LSB +: 8];
                end
                d.st = ST_RUN;
            end
            ST_RUN: begin
                if (take) begin
                    case (cmd)
                        CMD_CLS: begin
                            d.esr     = ZERO8;
                            d.stb     = ZERO8;
                            operation_summary_clr  = 1'b1;
                            questionable_summary_clr  = 1'b1;
                            d.err_clr = 1'b1;
                        end
                        CMD_ESE_W: begin
                            d.ese      = CMD_PARAM;
                            d.nv_store = 1'b1;
                        end
                        CMD_ESE_Q: begin
                            d.rsp_valid = 1'b1;
                            d.rsp_data  = q.ese;
                        end
                        CMD_ESR_Q: begin
                            d.rsp_valid = 1'b1;
                            d.rsp_data  = q.esr;
                            d.esr       = ZERO8;
                        end
                        CMD_IDN_Q: begin
                            // parser asks field by field and puts the commas between
                            d.rsp_valid = 1'b1;
                            case (CMD_PARAM[1:0])
                                2'd0:    d.rsp_data = MAKER_ID;
                                2'd1:    d.rsp_data = MODEL_ID;
                                2'd2:    d.rsp_data = SERIAL_ID;
                                default: d.rsp_data = VERSION_ID;
                            endcase
                        end
                        CMD_OPC_W: d.opc_set_pend = 1'b1;
                        CMD_OPC_Q: d.opc_ans_pend = 1'b1;
                        CMD_PSC_W: begin
                            d.psc      = CMD_PARAM != ZERO8;
                            d.nv_store = 1'b1;
                        end
                        CMD_PSC_Q: begin
                            d.rsp_valid = 1'b1;
                            d.rsp_data  = {7'h00, q.psc};
                        end
                        CMD_SRE_W: begin
                            d.sre      = CMD_PARAM;
                            d.nv_store = 1'b1;
                        end
                        CMD_SRE_Q: begin
                            d.rsp_valid = 1'b1;
                            d.rsp_data  = q.sre;
                        end
                        CMD_STB_Q: begin
                            d.rsp_valid = 1'b1;
                            d.rsp_data  = q.stb;
                            d.stb       = ZERO8;
                        end
                        CMD_QEV_Q: begin
                            d.rsp_valid = 1'b1;
                            d.rsp_data  = questionable_summary_evt;
                            questionable_summary_clr    = 1'b1;
                        end
                        CMD_QCND_Q: begin
                            d.rsp_valid = 1'b1;
                            d.rsp_data  = questionable_summary_cond;
                        end
                        CMD_QEN_W: begin
                            d.qen      = CMD_PARAM;
                            d.nv_store = 1'b1;
                        end
                        CMD_QEN_Q: begin
                            d.rsp_valid = 1'b1;
                            d.rsp_data  = q.qen;
                        end
                        CMD_OEV_Q: begin
                            d.rsp_valid = 1'b1;
                            d.rsp_data  = operation_summary_evt;
                            operation_summary_clr    = 1'b1;
                        end
                        CMD_OCND_Q: begin
                            d.rsp_valid = 1'b1;
                            d.rsp_data  = operation_summary_cond;
                        end
                        CMD_OEN_W: begin
                            d.oen      = CMD_PARAM;
                            d.nv_store = 1'b1;
                        end
                        CMD_OEN_Q: begin
                            d.rsp_valid = 1'b1;
                            d.rsp_data  = q.oen;
                        end
                        default: d.rsp_valid = 1'b0;
                    endcase
                end
            end
            default: d.st = ST_LOAD;
        endcase
        // operation complete waits for the executor to drain
        if (q.opc_set_pend && EXEC_IDLE) begin
            esr_set[ESR_OPC] = 1'b1;
            d.opc_set_pend   = 1'b0;
        end
        // a pending answer yields to a query answered in the same cycle
        if (q.opc_ans_pend && EXEC_IDLE && !d.rsp_valid) begin
            d.rsp_valid    = 1'b1;
            d.rsp_data     = 8'h01;
            d.opc_ans_pend = 1'b0;
        end
        // events set after any clear, so a coincident event survives
        d.esr = d.esr | esr_set;
        if (|(esr_set & ~q.esr & q.ese)) d.stb[STB_ESB] = 1'b1;
        if (questionable_summary_hit) d.stb[STB_QUESTIONABLE_SUMMARY] = 1'b1;
        if (operation_summary_hit) d.stb[STB_OPERATION_SUMMARY] = 1'b1;
        d.stb[STB_RQS] = |(d.stb & d.sre & STB_RQS_EXCL);
    end

    // state register; reset marks power-on in the event register
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            q     <= '0;
            q.st  <= ST_LOAD;
            q.esr <= ESR_RESET;
        end else begin
            q <= d;
        end
    end

    // every output is a state field
    assign RSP_VALID       = q.rsp_valid;
    assign RSP_DATA        = q.rsp_data;
    assign ERROR_CLEAR     = q.err_clr;
    assign NV_STORE        = q.nv_store;
    assign NV_IMAGE        = {q.psc, q.sre, q.ese, q.qen, q.oen};
    assign SERVICE_REQUEST = q.stb[STB_RQS];

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_pon_after_reset: assert property (@(posedge CORE_CLK) disable iff (RST)
        $past(q.st == ST_LOAD) |-> q.esr[ESR_PON])
        else $error("power-on bit missing after reset");

    a_esr_read_clear: assert property (@(posedge CORE_CLK) disable iff (RST)
        (take && cmd == CMD_ESR_Q) |=> (RSP_VALID && RSP_DATA == $past(q.esr) && (q.esr & ~$past(esr_set)) == 8'h00))
        else $error("event status query did not return and clear");

    a_esb_summary: assert property (@(posedge CORE_CLK) disable iff (RST)
        |(esr_set & ~q.esr & q.ese) |=> q.stb[STB_ESB])
        else $error("enabled standard event did not set summary bit");

    a_questionable_summary_summary: assert property (@(posedge CORE_CLK) disable iff (RST)
        questionable_summary_hit |=> q.stb[STB_QUESTIONABLE_SUMMARY])
        else $error("questionable summary not set");

    a_operation_summary_summary: assert property (@(posedge CORE_CLK) disable iff (RST)
        operation_summary_hit |=> q.stb[STB_OPERATION_SUMMARY])
        else $error("operation summary not set");

    a_rqs_tracks: assert property (@(posedge CORE_CLK) disable iff (RST)
        q.stb[STB_RQS] == |(q.stb & q.sre & STB_RQS_EXCL))
        else $error("request-service bit disagrees with enabled status bits");

    a_cls_clears: assert property (@(posedge CORE_CLK) disable iff (RST)
        (take && cmd == CMD_CLS && !questionable_summary_hit && !operation_summary_hit && esr_set == 8'h00) |=>
        (ERROR_CLEAR && q.esr == 8'h00 && q.stb == 8'h00))
        else $error("clear-status left state behind");

    a_ese_store: assert property (@(posedge CORE_CLK) disable iff (RST)
        (take && cmd == CMD_ESE_W) |=> (q.ese == $past(CMD_PARAM) && NV_STORE))
        else $error("standard event enable not stored");

    a_psc_clears: assert property (@(posedge CORE_CLK) disable iff (RST)
        ($past(q.st == ST_LOAD) && $past(NV_RESTORE_IN[NV_PSC_POS])) |-> (q.ese == 8'h00 && q.qen == 8'h00 && q.oen == 8'h00))
        else $error("power-on-clear did not clear masks");

    a_opc_sets: assert property (@(posedge CORE_CLK) disable iff (RST)
        (q.opc_set_pend && EXEC_IDLE) |=> q.esr[ESR_OPC])
        else $error("operation complete not flagged");

    a_stb_read_clear: assert property (@(posedge CORE_CLK) disable iff (RST)
        (take && cmd == CMD_STB_Q && !questionable_summary_hit && !operation_summary_hit && esr_set == 8'h00) |=> (RSP_DATA == $past(q.stb) && q.stb == 8'h00))
        else $error("status byte query did not return and clear");

endmodule : scpi_status_reporting

/* File: verilog/status_pkg.sv */
// status reporting constants, command codes and state types
package status_pkg;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    // operation condition bits
    localparam int OPC_CAL_POS  = 0;
    localparam int OPC_WTG_POS  = 1;
    localparam int OPC_CV_POS   = 2;
    localparam int OPC_CC_POS   = 3;
    localparam int OPC_RI_POS   = 4;
    // questionable condition bits
    localparam int QC_OV_POS    = 0;
    localparam int QC_OT_POS    = 1;
    localparam int QC_UNR_POS   = 2;
    // standard event status bits, same layout for the enable mask
    localparam int ESR_OPC      = 0;
    localparam int ESR_QYE      = 2;
    localparam int ESR_DDE      = 3;
    localparam int ESR_EXE      = 4;
    localparam int ESR_CME      = 5;
    localparam int ESR_PON      = 7;
    // status byte bits
    localparam int STB_QUESTIONABLE_SUMMARY     = 3;
    localparam int STB_ESB      = 5;
    localparam int STB_RQS      = 6;
    localparam int STB_OPERATION_SUMMARY     = 7;
    localparam logic [7:0] STB_RQS_EXCL = 8'hBF;

    // ------------------------------------------------------------
    // reset values and nonvolatile image layout
    // ------------------------------------------------------------
    localparam logic [7:0] ESR_RESET = 8'h80;
    localparam logic [7:0] ZERO8     = 8'h00;
    localparam int NV_PSC_POS  = 32;
    localparam int NV_SRE_LSB  = 24;
    localparam int NV_ESE_LSB  = 16;
    localparam int NV_QEN_LSB  = 8;
    localparam int NV_OEN_LSB  = 0;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_LOAD = 2'b01,
        ST_RUN  = 2'b10
    } state_t;

    typedef enum logic [4:0] {
        CMD_CLS    = 5'h00,
        CMD_ESE_W  = 5'h01,
        CMD_ESE_Q  = 5'h02,
        CMD_ESR_Q  = 5'h03,
        CMD_IDN_Q  = 5'h04,
        CMD_OPC_W  = 5'h05,
        CMD_OPC_Q  = 5'h06,
        CMD_PSC_W  = 5'h07,
        CMD_PSC_Q  = 5'h08,
        CMD_SRE_W  = 5'h09,
        CMD_SRE_Q  = 5'h0A,
        CMD_STB_Q  = 5'h0B,
        CMD_QEV_Q  = 5'h0C,
        CMD_QCND_Q = 5'h0D,
        CMD_QEN_W  = 5'h0E,
        CMD_QEN_Q  = 5'h0F,
        CMD_OEV_Q  = 5'h10,
        CMD_OCND_Q = 5'h11,
        CMD_OEN_W  = 5'h12,
        CMD_OEN_Q  = 5'h13
    } cmd_t;

endpackage : status_pkg
